// File: include/frame_sync_lock_monitor_pkg.sv
// Types shared by the frame sync and lock monitor
package frame_sync_lock_monitor_pkg;
  typedef logic [31:0]        word_t;    // Bus data word
  typedef logic signed [7:0]  jitter_t;  // Buffer fill offset in frames
  typedef logic [3:0]         events_t;  // Sticky event bits
endpackage

// File: include/frame_sync_lock_monitor_regs.svh
// Constants of the frame sync and lock monitor
`ifndef FRAME_SYNC_LOCK_MONITOR_REGS_SVH
`define FRAME_SYNC_LOCK_MONITOR_REGS_SVH

// Clock and timing
`define CLK_RATE_HZ          10000000
`define CLK_PERIOD_NS        100
`define LOCK_SAMPLE_RATE_HZ  460
`define LOCK_SAMPLE_CYCLES   (`CLK_RATE_HZ / `LOCK_SAMPLE_RATE_HZ)
`define LOCK_LOW_SAMPLES     8
`define READ_FRAME_PERIOD_NS 136000
`define READ_FRAME_CYCLES    (`READ_FRAME_PERIOD_NS / `CLK_PERIOD_NS)
`define READ_FRAME_HALF      (`READ_FRAME_CYCLES / 2)
`define JITTER_MARGIN_FRAMES 28

// Register byte offsets
`define ADDR_CONTROL 4'h0
`define ADDR_EVENTS  4'h4
`define ADDR_MASK    4'h8
`define ADDR_STATE   4'hc

// Control fields
`define CTRL_LOCK_INPUT  0
`define CTRL_ROUTE_SCOR  1
`define CTRL_FSW_LEVEL   2

// Event and state fields
`define EV_LOCK_LOST     0
`define EV_LOCK_GAINED   1
`define EV_OVERFLOW      2
`define EV_C2_ERROR      3
`define EV_WIDTH         4
`define ST_LOCK          0
`define ST_SYNC_GOOD     1
`define ST_WINDOW        2
`define ST_OVERFLOW      3
`define ST_LOCK_PIN_IN   4

`define HTRANS_NONSEQ_BIT 1
`define HRESP_OKAY        1'b0

`endif

// File: logic/frame_sync_lock_monitor.sv
// Frame sync, lock and status monitor with AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "frame_sync_lock_monitor_regs.svh"

module frame_sync_lock_monitor #(
  parameter int SAMPLE_DIV = `LOCK_SAMPLE_CYCLES, // Clocks between lock samples
  parameter int LOW_COUNT  = `LOCK_LOW_SAMPLES,   // Low samples before unlock
  parameter int FRAME_HALF = `READ_FRAME_HALF     // Half period of frame clock
) (
  input  wire logic                              clk,
  input  wire logic                              reset,
  // AHB-Lite slave
  input  wire logic                              hsel,
  input  wire logic [31:0]                       haddr,
  input  wire logic [1:0]                        htrans,
  input  wire logic                              hwrite,
  input  wire logic [2:0]                        hsize,
  input  wire logic                              hready,
  input  wire frame_sync_lock_monitor_pkg::word_t hwdata,
  output var  frame_sync_lock_monitor_pkg::word_t hrdata,
  output logic                                   hreadyout,
  output logic                                   hresp,
  output logic                                   irq,
  // Disc core signals, same clock
  input  wire logic                              sync_detected,
  input  wire logic                              sync_expected,
  input  wire logic                              window_released,
  input  wire logic                              pll_clock,
  input  wire logic                              c2_error,
  input  wire frame_sync_lock_monitor_pkg::jitter_t frame_jitter,
  input  wire logic                              subcode_sync,
  // Pins
  input  wire logic                              resync_request,
  input  wire logic                              lock_in,
  output logic                                   lock_out,
  output logic                                   lock_oe_n,
  output logic                                   frame_sync_good,
  output logic                                   sync_window_released_mon,
  output logic                                   raw_frame_sync_n,
  output logic                                   pll_clock_inverted,
  output logic                                   read_frame_clock,
  output logic                                   buffer_jitter_overflow,
  output logic                                   second_stage_error_flag,
  output logic                                   resynced_subcode_sync,
  output logic                                   spindle_filter_switch
);
  import frame_sync_lock_monitor_pkg::*;

  localparam int DIV_W = $clog2(SAMPLE_DIV + 1); // Sample divider width
  localparam int LOW_W = $clog2(LOW_COUNT + 1);  // Low run counter width
  localparam int RFC_W = $clog2(FRAME_HALF + 1); // Frame clock counter width
  localparam jitter_t MARGIN = jitter_t'(`JITTER_MARGIN_FRAMES);

  // Synchronisers for pin inputs
  logic lock_meta, lock_sync;       // Lock pin when used as input
  logic resync_meta, resync_sync;   // Resync request pin
  logic resync_prev;                // Edge detect of resync request

  // Bus state
  logic       acc_valid, next_acc_valid;    // Data phase pending
  logic       acc_write, next_acc_write;    // Pending access is a write
  logic [3:0] acc_addr,  next_acc_addr;     // Pending byte offset
  word_t      next_hrdata;                  // Read data for data phase

  // Registers
  logic [2:0] control, next_control;        // Control bits
  events_t    events,  next_events;         // Sticky events
  events_t    mask,    next_mask;           // Interrupt mask

  // Monitor state
  logic [DIV_W-1:0] div_cnt, next_div_cnt;  // 460 Hz sample divider
  logic [LOW_W-1:0] low_cnt, next_low_cnt;  // Consecutive low samples
  logic             lock,    next_lock;     // Lock indicator
  logic [RFC_W-1:0] rfc_cnt, next_rfc_cnt;  // Frame clock divider
  logic             next_rfc;               // Frame clock next level
  logic             next_gfs;               // Sync-good next value
  logic             next_ovf;               // Overflow next value
  logic             next_scor;              // Resynced subcode sync next
  logic             sample_tick;            // One-cycle sample enable
  logic             lock_src;               // Lock level seen by software
  logic             bus_take;               // Address phase accepted

  // Two-flop synchronisers; the first stage feeds only the second, resync_prev feeds the edge detect
  always_ff @(posedge clk) begin
    if (reset) begin
      lock_meta   <= 1'b0;
      lock_sync   <= 1'b0;
      resync_meta <= 1'b0;
      resync_sync <= 1'b0;
      resync_prev <= 1'b0;
    end else begin
      lock_meta   <= lock_in;
      lock_sync   <= lock_meta;
      resync_meta <= resync_request;
      resync_sync <= resync_meta;
      resync_prev <= resync_sync;
    end
  end

  // Always ready, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = `HRESP_OKAY;
  assign bus_take  = hsel & htrans[`HTRANS_NONSEQ_BIT] & hready;
  assign irq       = |(events & mask);
  assign lock_src  = control[`CTRL_LOCK_INPUT] ? lock_sync : lock;

  // Bus and register next values
  always_comb begin
    next_acc_valid = bus_take;
    next_acc_write = hwrite;
    next_acc_addr  = haddr[3:0];
    next_control   = control;
    next_mask      = mask;
    next_events    = events;
    next_hrdata    = hrdata;
    // Write in data phase
    if (acc_valid && acc_write) begin
      case (acc_addr)
        `ADDR_CONTROL: next_control = hwdata[2:0];
        `ADDR_MASK:    next_mask    = hwdata[`EV_WIDTH-1:0];
        default:       next_control = control;
      endcase
    end
    // Read data captured at address phase
    if (bus_take && !hwrite) begin
      case (haddr[3:0])
        `ADDR_CONTROL: next_hrdata = {29'h0, control};
        `ADDR_EVENTS: begin
          next_hrdata = {28'h0, events};
          next_events = '0;           // Read clears
        end
        `ADDR_MASK:    next_hrdata = {28'h0, mask};
        `ADDR_STATE:   next_hrdata = {27'h0, control[`CTRL_LOCK_INPUT], buffer_jitter_overflow,
                                      sync_window_released_mon, frame_sync_good, lock_src};
        default:       next_hrdata = 32'h0;  // Unmapped reads zero
      endcase
    end
    // New events win over the read clear
    if (sample_tick && lock && !next_lock)
      next_events[`EV_LOCK_LOST] = 1'b1;
    if (sample_tick && !lock && next_lock)
      next_events[`EV_LOCK_GAINED] = 1'b1;
    if (next_ovf && !buffer_jitter_overflow)
      next_events[`EV_OVERFLOW] = 1'b1;
    if (c2_error && !second_stage_error_flag)
      next_events[`EV_C2_ERROR] = 1'b1;
  end

  // Bus and register flops
  always_ff @(posedge clk) begin
    if (reset) begin
      acc_valid <= 1'b0;
      acc_write <= 1'b0;
      acc_addr  <= 4'h0;
      hrdata    <= 32'h0;
      control   <= 3'h0;
      events    <= '0;
      mask      <= '0;
    end else begin
      acc_valid <= next_acc_valid;
      acc_write <= next_acc_write;
      acc_addr  <= next_acc_addr;
      hrdata    <= next_hrdata;
      control   <= next_control;
      events    <= next_events;
      mask      <= next_mask;
    end
  end

  // Lock sampling next values
  always_comb begin
    sample_tick  = (div_cnt == DIV_W'(SAMPLE_DIV - 1));
    next_div_cnt = sample_tick ? '0 : div_cnt + DIV_W'(1);
    next_low_cnt = low_cnt;
    next_lock    = lock;
    if (sample_tick) begin
      if (frame_sync_good) begin
        next_lock    = 1'b1;
        next_low_cnt = '0;
      end else if (low_cnt == LOW_W'(LOW_COUNT - 1)) begin
        next_lock    = 1'b0;
        next_low_cnt = low_cnt;
      end else begin
        next_low_cnt = low_cnt + LOW_W'(1); // Short low runs keep lock
      end
    end
  end

  // Lock sampling flops
  always_ff @(posedge clk) begin
    if (reset) begin
      div_cnt <= '0;
      low_cnt <= '0;
      lock    <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      low_cnt <= next_low_cnt;
      lock    <= next_lock;
    end
  end

  // Lock pin drive; released when input is selected
  assign lock_out  = lock;
  assign lock_oe_n = control[`CTRL_LOCK_INPUT];

  // Monitor next values
  always_comb begin
    next_gfs = frame_sync_good;
    if (sync_expected)
      next_gfs = sync_detected;
    next_rfc     = read_frame_clock;
    next_rfc_cnt = rfc_cnt + RFC_W'(1);
    if (rfc_cnt == RFC_W'(FRAME_HALF - 1)) begin
      next_rfc_cnt = '0;
      next_rfc     = ~read_frame_clock;
    end
    next_ovf  = (frame_jitter > MARGIN) || (frame_jitter < -MARGIN);
    next_scor = resynced_subcode_sync;
    if (resync_sync && !resync_prev)
      next_scor = 1'b0;                    // Resync restarts the sync
    else if (subcode_sync)
      next_scor = 1'b1;
  end

  // Monitor flops
  always_ff @(posedge clk) begin
    if (reset) begin
      frame_sync_good          <= 1'b0;
      sync_window_released_mon <= 1'b0;
      raw_frame_sync_n         <= 1'b1;
      pll_clock_inverted       <= 1'b1;
      read_frame_clock         <= 1'b0;
      rfc_cnt                  <= '0;
      buffer_jitter_overflow   <= 1'b0;
      second_stage_error_flag  <= 1'b0;
      resynced_subcode_sync    <= 1'b0;
      spindle_filter_switch    <= 1'b0;
    end else begin
      frame_sync_good          <= next_gfs;
      sync_window_released_mon <= window_released;
      raw_frame_sync_n         <= ~sync_detected;
      pll_clock_inverted       <= ~pll_clock;
      read_frame_clock         <= next_rfc;
      rfc_cnt                  <= next_rfc_cnt;
      buffer_jitter_overflow   <= next_ovf;
      second_stage_error_flag  <= c2_error;
      resynced_subcode_sync    <= next_scor;
      // Filter switch or resynced sync
      spindle_filter_switch    <= control[`CTRL_ROUTE_SCOR] ? next_scor : control[`CTRL_FSW_LEVEL];
    end
  end

endmodule
`default_nettype wire

// File: test/cpu_pin_model.sv
// Microcontroller side of the lock pin and resync input
`timescale 1ns/1ps
`default_nettype none
module cpu_pin_model (
  input  wire logic lock_out,
  input  wire logic lock_oe_n,
  input  wire logic cpu_level,
  input  wire logic cpu_resync,
  output logic      lock_in,
  output logic      resync_request
);
  // Pin level: device drives while enable low, host otherwise
  assign lock_in = lock_oe_n ? cpu_level : lock_out;
  // Host raises resync on command
  assign resync_request = cpu_resync;
endmodule
`default_nettype wire

// File: test/frame_sync_lock_monitor_assertions.sv
// Concurrent checks on the monitor outputs
`timescale 1ns/1ps
`default_nettype none
module fslm_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic sync_detected,
  input wire logic sync_expected,
  input wire logic window_released,
  input wire logic pll_clock,
  input wire logic c2_error,
  input wire frame_sync_lock_monitor_pkg::jitter_t frame_jitter,
  input wire logic lock_out,
  input wire logic frame_sync_good,
  input wire logic sync_window_released_mon,
  input wire logic raw_frame_sync_n,
  input wire logic pll_clock_inverted,
  input wire logic buffer_jitter_overflow,
  input wire logic second_stage_error_flag
);
  import frame_sync_lock_monitor_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Nine good cycles always contain one sample tick
  sequence s_good_run;
    frame_sync_good [*8] ##1 frame_sync_good;
  endsequence
  a_lock_gain: assert property (s_good_run |-> ##[0:2] lock_out)
    else $error("lock not raised");
  a_lock_drop: assert property ($fell(lock_out) |-> !$past(frame_sync_good) || !$past(frame_sync_good, 2))
    else $error("lock dropped on good sample");
  a_good_take: assert property (!$past(reset) && $past(sync_expected) |-> frame_sync_good == $past(sync_detected))
    else $error("sync good not taken");
  a_good_hold: assert property (!$past(reset) && !$past(sync_expected) |-> $stable(frame_sync_good))
    else $error("sync good moved");
  a_window_mon: assert property (!$past(reset) |-> sync_window_released_mon == $past(window_released))
    else $error("window monitor wrong");
  a_raw_sync: assert property (!$past(reset) |-> raw_frame_sync_n == !$past(sync_detected))
    else $error("raw sync wrong");
  a_pll_inv: assert property (!$past(reset) |-> pll_clock_inverted == !$past(pll_clock))
    else $error("pll clock not inverted");
  a_jitter_flag: assert property (!$past(reset) |->
    buffer_jitter_overflow == ($past(frame_jitter) > 28 || $past(frame_jitter) < -28))
    else $error("overflow flag wrong");
  a_error_flag: assert property (!$past(reset) |-> second_stage_error_flag == $past(c2_error))
    else $error("error flag wrong");
endmodule
bind frame_sync_lock_monitor fslm_checker i_fslm_checker (.*);
`default_nettype wire

// File: test/tb_frame_sync_lock_monitor.sv
// Self-checking bench of the frame sync and lock monitor
`timescale 1ns/1ps
`default_nettype none
module tb_frame_sync_lock_monitor;
  import frame_sync_lock_monitor_pkg::*;
  localparam int SD = 8;  // Short sample spacing
  localparam int FH = 5;  // Short frame clock half period
  logic clk = 0, reset = 1, hsel = 0, hwrite = 0, sync_detected = 0, sync_expected = 0, subcode_sync = 0;
  logic window_released = 0, pll_clock = 0, c2_error = 0, cpu_level = 0, cpu_resync = 0;
  logic [31:0] haddr = 0;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;  // Word transfers only
  word_t       hwdata = 0, hrdata, q;
  jitter_t     frame_jitter = 0;
  logic hreadyout, hresp, irq, resync_request, lock_in, lock_out, lock_oe_n, frame_sync_good;
  logic sync_window_released_mon, raw_frame_sync_n, pll_clock_inverted, read_frame_clock;
  logic buffer_jitter_overflow, second_stage_error_flag, resynced_subcode_sync, spindle_filter_switch;
  wire  hready = hreadyout;  // One slave drives the bus ready
  int   n_fail = 0, n_checks = 0, n, m, fsg_m = 0;
  always #50 clk = ~clk;
  frame_sync_lock_monitor #(.SAMPLE_DIV(SD), .FRAME_HALF(FH)) i_frame_sync_lock_monitor (.*);
  cpu_pin_model i_cpu_pin_model (.*);
  // Verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Compare one result
  task automatic cmp(input word_t got, input word_t exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Wait for bus ready, bounded
  task automatic hw();
    int i;
    for (i = 0; i < 99; i++) begin
      @(posedge clk);
      if (hready === 1'b1) break;
    end
    if (i == 99) begin
      n_fail++;
      wrap_up();
    end
  endtask
  // One single AHB transfer; read data lands in q
  task automatic bus(input logic w, input word_t a, input word_t d);
    @(posedge clk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, a};
    hw();
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    hw();
    q = hrdata;
  endtask
  // Count falling edges until a level shows, bounded
  task automatic till(ref logic s, input logic v, output int c);
    for (c = 0; s !== v; c++) begin
      if (c == 300) begin
        n_fail++;
        wrap_up();
      end
      @(negedge clk);
    end
  endtask
  initial begin
    void'($urandom(32'hd9f5));
    repeat (20) @(posedge clk);
    reset <= 0;
    // Random disc core traffic against the bench model
    for (int k = 0; k < 300; k++) begin
      @(posedge clk);
      {sync_detected, sync_expected, window_released, pll_clock, c2_error} <= 5'($urandom);
      frame_jitter <= jitter_t'($urandom_range(80) - 40);
      @(posedge clk);
      #1;
      if (sync_expected) fsg_m = sync_detected;
      cmp(frame_sync_good, fsg_m);
      cmp(sync_window_released_mon, window_released);
      cmp(raw_frame_sync_n, !sync_detected);
      cmp(pll_clock_inverted, !pll_clock);
      cmp(buffer_jitter_overflow, frame_jitter > 28 || frame_jitter < -28);
      cmp(second_stage_error_flag, c2_error);
    end
    // Lock gain, short low run, then full low run
    @(posedge clk);
    {sync_expected, sync_detected, c2_error, frame_jitter} <= {3'b110, 8'h00};
    repeat (30) @(posedge clk);
    #1 cmp(lock_out, 1);
    bus(0, 32'h4, 0);
    @(posedge clk);
    sync_detected <= 0;
    repeat (40) @(posedge clk);
    #1 cmp(lock_out, 1);
    @(posedge clk);
    sync_detected <= 1;
    repeat (12) @(posedge clk);
    sync_detected <= 0;
    till(lock_out, 1'b0, n);
    cmp(n >= 7 * SD + 1 && n <= 8 * SD + 16, 1);
    // Event masked, unmasked, then cleared by read
    cmp(irq, 0);
    bus(1, 32'h8, 32'h1);
    #1 cmp(irq, 1);
    bus(0, 32'h4, 0);
    cmp(q, 32'h1);
    #1 cmp(irq, 0);
    bus(0, 32'h10, 0);
    cmp(q, 32'h0);
    // Lock pin released to the host
    bus(1, 32'h0, 32'h1);
    #1 cmp(lock_oe_n, 1);
    @(posedge clk);
    cpu_level <= 1;
    repeat (3) @(posedge clk);
    bus(0, 32'hc, 0);
    cmp(q & 32'h11, 32'h11);
    bus(1, 32'h0, 32'h0);
    #1 cmp(lock_oe_n, 0);
    // Resynced subcode sync on the filter switch
    bus(1, 32'h0, 32'h2);
    subcode_sync <= 1;
    @(posedge clk);
    subcode_sync <= 0;
    @(posedge clk);
    #1 cmp({resynced_subcode_sync, spindle_filter_switch}, 2'b11);
    @(posedge clk);
    cpu_resync <= 1;
    repeat (6) @(posedge clk);
    cpu_resync <= 0;
    #1 cmp({resynced_subcode_sync, spindle_filter_switch}, 2'b00);
    bus(1, 32'h0, 32'h4);
    // Level bit lands at the data edge, the pin follows one clock later
    @(posedge clk);
    #1 cmp(spindle_filter_switch, 1);
    cmp({hreadyout, hresp}, 2'b10);
    // Read frame clock period
    till(read_frame_clock, 1'b0, n);
    till(read_frame_clock, 1'b1, n);
    till(read_frame_clock, 1'b0, n);
    till(read_frame_clock, 1'b1, m);
    cmp(n + m, 2 * FH);
    wrap_up();
  end
endmodule
`default_nettype wire
